// ===== verilog/timer16_pkg.sv
package timer16_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_COMPARE_A = 12'h004;
  localparam logic [11:0] OFF_CAPTURE_TOP = 12'h008;
  localparam logic [11:0] OFF_COUNTER = 12'h00C;
  localparam logic [11:0] OFF_FLAGS = 12'h010;
  localparam logic [11:0] OFF_ACTIVE_A = 12'h014;

  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ACTION_LSB = 4;
  localparam int CTL_PRESC_LSB = 8;
  localparam int CTL_DIR_BIT = 12;

  // Flags register bit positions
  localparam int FLG_OVERFLOW = 0;
  localparam int FLG_COMPARE_A = 1;
  localparam int FLG_CAPTURE = 2;

  // Waveform mode encodings
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_A = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A = 4'hF;

  // Output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;

  // Fixed TOP values and limits
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] BOTTOM = 16'h0000;

  // Prescaler select codes and divide ratios
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_DIV1 = 3'h1;
  localparam logic [2:0] PRE_DIV8 = 3'h2;
  localparam logic [2:0] PRE_DIV64 = 3'h3;
  localparam logic [2:0] PRE_DIV256 = 3'h4;
  localparam logic [2:0] PRE_DIV1024 = 3'h5;
  localparam int DIV8 = 8;
  localparam int DIV64 = 64;
  localparam int DIV256 = 256;
  localparam int DIV1024 = 1024;

  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DIR_UP = 2'b00,
    DIR_DOWN = 2'b01
  } count_dir_t;

endpackage : timer16_pkg

// ===== verilog/timer16_prescaler.sv
`timescale 1ns/10ps
module timer16_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Divide select
  input wire logic [2:0] presc_sel,
  // Timer clock enable
  output logic tick
);

  logic [9:0] div_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 10'h000;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

  // One enable per divided period
  always_comb begin
    case (presc_sel)
      timer16_pkg::PRE_DIV1: tick = 1'b1;
      timer16_pkg::PRE_DIV8:
        tick = div_count[2:0] == 3'(timer16_pkg::DIV8 - 1);
      timer16_pkg::PRE_DIV64:
        tick = div_count[5:0] == 6'(timer16_pkg::DIV64 - 1);
      timer16_pkg::PRE_DIV256:
        tick = div_count[7:0] == 8'(timer16_pkg::DIV256 - 1);
      timer16_pkg::PRE_DIV1024:
        tick = div_count == 10'(timer16_pkg::DIV1024 - 1);
      default: tick = 1'b0;
    endcase
  end

endmodule : timer16_prescaler

// ===== verilog/timer16_top_select.sv
`timescale 1ns/10ps
module timer16_top_select (
  // Mode and TOP sources
  input wire logic [3:0] mode,
  input wire logic [15:0] compare_a_value,
  input wire logic [15:0] capture_top_value,
  // Selected TOP and mode class
  output logic [15:0] top,
  output logic is_ctc,
  output logic is_fast,
  output logic is_pc,
  output logic top_is_a,
  output logic top_is_cap,
  output logic [15:0] fixed_mask
);

  always_comb begin
    top = timer16_pkg::COUNT_MAX;
    is_ctc = 1'b0;
    is_fast = 1'b0;
    is_pc = 1'b0;
    top_is_a = 1'b0;
    top_is_cap = 1'b0;
    fixed_mask = timer16_pkg::COUNT_MAX;
    case (mode)
      timer16_pkg::MODE_CTC_A: begin
        is_ctc = 1'b1;
        top_is_a = 1'b1;
      end
      timer16_pkg::MODE_CTC_CAP: begin
        is_ctc = 1'b1;
        top_is_cap = 1'b1;
      end
      timer16_pkg::MODE_FAST8, timer16_pkg::MODE_PC8: begin
        fixed_mask = timer16_pkg::TOP_8BIT;
      end
      timer16_pkg::MODE_FAST9, timer16_pkg::MODE_PC9: begin
        fixed_mask = timer16_pkg::TOP_9BIT;
      end
      timer16_pkg::MODE_FAST10, timer16_pkg::MODE_PC10: begin
        fixed_mask = timer16_pkg::TOP_10BIT;
      end
      timer16_pkg::MODE_FAST_CAP, timer16_pkg::MODE_PC_CAP: begin
        top_is_cap = 1'b1;
      end
      timer16_pkg::MODE_FAST_A, timer16_pkg::MODE_PC_A: begin
        top_is_a = 1'b1;
      end
      default: begin
      end
    endcase
    case (mode)
      timer16_pkg::MODE_FAST8, timer16_pkg::MODE_FAST9,
      timer16_pkg::MODE_FAST10, timer16_pkg::MODE_FAST_CAP,
      timer16_pkg::MODE_FAST_A: is_fast = 1'b1;
      timer16_pkg::MODE_PC8, timer16_pkg::MODE_PC9,
      timer16_pkg::MODE_PC10, timer16_pkg::MODE_PC_CAP,
      timer16_pkg::MODE_PC_A: is_pc = 1'b1;
      default: begin
      end
    endcase
    if (top_is_a) begin
      top = compare_a_value;
    end else if (top_is_cap) begin
      top = capture_top_value;
    end else if (is_fast || is_pc) begin
      top = fixed_mask;
    end
  end

endmodule : timer16_top_select

// ===== verilog/timer16_waveform.sv
// Notes on behaviour
// - Mode 4 is clear-on-match with compare A TOP; 12 uses capture TOP.
// - Clear-on-match counts up to selected TOP, then returns to zero.
// - Clear-on-match sets compare A or capture flag at TOP.
// - Clear-on-match TOP unbuffered; TOP below count wraps via 0xFFFF first.
// - Clear-on-match action 1 toggles output A on each match.
// - Output A reaches pin only when its direction bit is output.
// - Clear-on-match sets overflow when count passes max to zero.
// - Modes 5,6,7,14,15 are fast PWM, counting BOTTOM to TOP.
// - Fast PWM TOP fixed, capture or compare A; clears cycle after TOP.
// - Fast PWM action 2 clears on match, sets at BOTTOM; 3 inverts.
// - Fast PWM sets overflow at TOP, plus the TOP register flag.
// - PWM compare A writes buffered; active loads at TOP.
// - Capture TOP unbuffered; below count wraps via 0xFFFF.
// - Fixed-TOP modes mask compare writes above the resolution.
// - Fast PWM compare zero spikes; compare equal TOP gives constant level.
// - Fast mode 15 with action 1 toggles A at 50% duty.
// - Modes 1,2,3,10,11 are phase-correct, counting up then down.
// - Phase-correct TOP fixed, capture or compare A; holds TOP one tick.
// - Phase-correct: clear on up match, set on down match; flag set.
// - Phase-correct overflow at BOTTOM; buffers load at TOP with TOP flag.
// - Counter advances only on prescaled enables: 1,8,64,256,1024.
// - Action 0 leaves the output register unchanged.
`timescale 1ns/10ps
module timer16_waveform (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pin for channel A
  output logic wave_out_a,
  output logic wave_out_a_oe
);

  logic [31:0] control;
  logic [15:0] compare_a_buffer;
  logic [15:0] compare_a_value;
  logic [15:0] capture_top_value;
  logic [15:0] counter_value;
  logic overflow_flag;
  logic compare_a_flag;
  logic capture_flag;
  logic wave_a;
  timer16_pkg::count_dir_t dir;

  logic [3:0] waveform_mode_sel;
  logic [1:0] output_action_sel_a;
  logic [2:0] presc_sel;
  logic pin_dir_out_a;
  logic tick;
  logic [15:0] top;
  logic is_ctc;
  logic is_fast;
  logic is_pc;
  logic top_is_a;
  logic top_is_cap;
  logic [15:0] fixed_mask;
  logic access;
  logic wr;
  logic flag_wr;
  logic cnt_wr;
  logic at_top;
  logic match_a;
  logic [15:0] next_counter;
  logic next_dir_down;
  logic ctl_wr;
  logic cmp_wr;
  logic cap_wr;
  logic pwm_mode;
  logic top_tick;
  logic bottom_tick;
  logic max_tick;
  logic match_tick;
  logic match_down;

  assign waveform_mode_sel = control[timer16_pkg::CTL_MODE_LSB +: 4];
  assign output_action_sel_a = control[timer16_pkg::CTL_ACTION_LSB +: 2];
  assign presc_sel = control[timer16_pkg::CTL_PRESC_LSB +: 3];
  assign pin_dir_out_a = control[timer16_pkg::CTL_DIR_BIT];

  timer16_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .presc_sel(presc_sel),
    .tick(tick)
  );

  timer16_top_select u_top (
    .mode(waveform_mode_sel),
    .compare_a_value(compare_a_value),
    .capture_top_value(capture_top_value),
    .top(top),
    .is_ctc(is_ctc),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .top_is_a(top_is_a),
    .top_is_cap(top_is_cap),
    .fixed_mask(fixed_mask)
  );

  // Single-cycle access phase, no wait states
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign flag_wr = wr && paddr == timer16_pkg::OFF_FLAGS;
  assign cnt_wr = wr && paddr == timer16_pkg::OFF_COUNTER;
  assign at_top = counter_value == top;
  assign match_a = counter_value == compare_a_value;
  assign ctl_wr = wr && paddr == timer16_pkg::OFF_CONTROL;
  assign cmp_wr = wr && paddr == timer16_pkg::OFF_COMPARE_A;
  assign cap_wr = wr && paddr == timer16_pkg::OFF_CAPTURE_TOP;

  // Timer events, each valid only on a tick
  assign pwm_mode = is_fast || is_pc;
  assign top_tick = tick && at_top;
  assign bottom_tick = tick && counter_value == timer16_pkg::BOTTOM;
  assign max_tick = tick && counter_value == timer16_pkg::COUNT_MAX;
  assign match_tick = tick && match_a;
  // Match while falling; the TOP cycle still counts as rising
  assign match_down = dir == timer16_pkg::DIR_DOWN && !at_top;

  // Next count and direction on a timer tick
  always_comb begin
    next_counter = counter_value + 16'h0001;
    next_dir_down = 1'b0;
    if (is_ctc || is_fast) begin
      if (at_top) begin
        next_counter = timer16_pkg::BOTTOM;
      end
    end else if (is_pc) begin
      next_dir_down = dir == timer16_pkg::DIR_DOWN;
      if (at_top) begin
        next_dir_down = 1'b1;
        next_counter = counter_value - 16'h0001;
      end else if (counter_value == timer16_pkg::BOTTOM) begin
        // Stale down state after a counter load turns at zero
        next_dir_down = 1'b0;
      end else if (next_dir_down) begin
        next_counter = counter_value - 16'h0001;
        if (counter_value == 16'h0001) begin
          next_dir_down = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= timer16_pkg::CONTROL_RESET;
    end else if (ctl_wr) begin
      control <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_top_value <= timer16_pkg::VALUE_RESET;
    end else if (cap_wr) begin
      capture_top_value <= pwdata[15:0];
    end
  end

  // Compare A buffer and active value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_buffer <= timer16_pkg::VALUE_RESET;
      compare_a_value <= timer16_pkg::VALUE_RESET;
    end else begin
      if (cmp_wr) begin
        compare_a_buffer <= pwdata[15:0] & fixed_mask;
      end
      // A write colliding with TOP loads the old buffer, not nothing
      if (pwm_mode && top_tick) begin
        compare_a_value <= compare_a_buffer;
      end else if (cmp_wr && !pwm_mode) begin
        compare_a_value <= pwdata[15:0] & fixed_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= timer16_pkg::VALUE_RESET;
      dir <= timer16_pkg::DIR_UP;
    end else if (cnt_wr) begin
      counter_value <= pwdata[15:0];
    end else if (tick) begin
      counter_value <= next_counter;
      dir <= next_dir_down ? timer16_pkg::DIR_DOWN : timer16_pkg::DIR_UP;
    end
  end

  // Flags: hardware set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (is_fast && top_tick) begin
      overflow_flag <= 1'b1;
    end else if (is_pc && bottom_tick) begin
      overflow_flag <= 1'b1;
    end else if (!pwm_mode && max_tick) begin
      overflow_flag <= 1'b1;
    end else if (flag_wr && pwdata[timer16_pkg::FLG_OVERFLOW]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_flag <= 1'b0;
    end else if (match_tick) begin
      compare_a_flag <= 1'b1;
    end else if (flag_wr && pwdata[timer16_pkg::FLG_COMPARE_A]) begin
      compare_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_flag <= 1'b0;
    end else if (top_is_cap && top_tick) begin
      capture_flag <= 1'b1;
    end else if (flag_wr && pwdata[timer16_pkg::FLG_CAPTURE]) begin
      capture_flag <= 1'b0;
    end
  end

  // Waveform register for channel A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_a <= 1'b0;
    end else if (tick) begin
      case (output_action_sel_a)
        timer16_pkg::ACT_TOGGLE: begin
          if (match_a && (is_ctc || waveform_mode_sel
                          == timer16_pkg::MODE_FAST_A
                          || waveform_mode_sel == timer16_pkg::MODE_PC_A
                          || !(is_fast || is_pc))) begin
            wave_a <= !wave_a;
          end
        end
        timer16_pkg::ACT_NONINV, timer16_pkg::ACT_INV: begin
          if (is_fast) begin
            // Match outranks TOP so compare equal TOP is constant
            if (match_a) begin
              wave_a <= output_action_sel_a == timer16_pkg::ACT_INV;
            end else if (at_top) begin
              wave_a <= output_action_sel_a == timer16_pkg::ACT_NONINV;
            end
          end else if (is_pc) begin
            if (match_a) begin
              wave_a <= match_down
                        ^ (output_action_sel_a == timer16_pkg::ACT_INV);
            end
          end else if (match_a) begin
            wave_a <= output_action_sel_a == timer16_pkg::ACT_INV;
          end
        end
        default: begin
          wave_a <= wave_a;
        end
      endcase
    end
  end

  // Pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_a <= 1'b0;
      wave_out_a_oe <= 1'b0;
    end else begin
      wave_out_a <= pin_dir_out_a ? wave_a : 1'b0;
      wave_out_a_oe <= pin_dir_out_a;
    end
  end

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        timer16_pkg::OFF_CONTROL: prdata <= {16'h0000, control[15:0]};
        timer16_pkg::OFF_COMPARE_A: prdata <= {16'h0000, compare_a_buffer};
        timer16_pkg::OFF_CAPTURE_TOP: prdata <= {16'h0000, capture_top_value};
        timer16_pkg::OFF_COUNTER: prdata <= {16'h0000, counter_value};
        timer16_pkg::OFF_FLAGS:
          prdata <= {29'h0, capture_flag, compare_a_flag,
                     overflow_flag};
        timer16_pkg::OFF_ACTIVE_A: prdata <= {16'h0000, compare_a_value};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : timer16_waveform

// ===== test/timer16_waveform_checker.sv
`timescale 1ns/10ps
module timer16_waveform_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe
);
  logic ctl_wr;
  logic rd_setup;
  logic [31:0] ctl;
  logic [2:0] stop_cnt;
  logic [2:0] idle_cnt;
  assign ctl_wr = psel & penable & pwrite & pready &
    (paddr == timer16_pkg::OFF_CONTROL);
  assign rd_setup = psel & !penable & !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl <= 32'h0;
    else if (ctl_wr) ctl <= pwdata;
  end
  // Cycles with the control word unchanged and the timer stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stop_cnt <= 3'h0;
    else if (ctl_wr || ctl[timer16_pkg::CTL_PRESC_LSB +: 3] != 3'h0)
      stop_cnt <= 3'h0;
    else if (stop_cnt != 3'h7) stop_cnt <= stop_cnt + 3'h1;
  end
  // Cycles with the control word unchanged and no output action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt <= 3'h0;
    else if (ctl_wr || ctl[timer16_pkg::CTL_ACTION_LSB +: 2] != 2'h0)
      idle_cnt <= 3'h0;
    else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_reset_a: assert property ($past(presetn) |-> pready)
    else $error("pready low out of reset");
  no_slave_error_a: assert property (!pslverr)
    else $error("pslverr raised");
  pin_masked_a: assert property (!wave_out_a_oe |-> !wave_out_a)
    else $error("pin driven while input");
  dir_write_a: assert property (ctl_wr |-> ##2
    (wave_out_a_oe == $past(pwdata[timer16_pkg::CTL_DIR_BIT], 2)))
    else $error("enable not from direction bit");
  unmapped_zero_a: assert property (rd_setup && paddr >= 12'h018 |=>
    prdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_setup |=> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  stopped_quiet_a: assert property (stop_cnt >= 3'h3 |->
    $stable(wave_out_a)) else $error("pin moved while stopped");
  no_action_a: assert property (idle_cnt >= 3'h3 |->
    $stable(wave_out_a)) else $error("pin moved with no action");
  cover property ($rose(wave_out_a));
  cover property (idle_cnt == 3'h7 && wave_out_a_oe);
  cover property (rd_setup && paddr >= 12'h018);
endmodule : timer16_waveform_checker

bind timer16_waveform timer16_waveform_checker chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wave_out_a(wave_out_a),
  .wave_out_a_oe(wave_out_a_oe));

// ===== test/timer16_pin_load.sv
`timescale 1ns/10ps
module timer16_pin_load (
  // Pin from the block
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe,
  // Level seen by the load
  output logic pin_level
);
  // Pull-down holds the line low while undriven
  assign pin_level = wave_out_a_oe ? wave_out_a : 1'b0;
endmodule : timer16_pin_load

// ===== test/timer16_waveform_test.sv
`timescale 1ns/10ps
module timer16_waveform_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wave_out_a;
  logic wave_out_a_oe;
  logic pin_level;
  logic [31:0] seed = 32'h68C69CA1;
  logic [31:0] q;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  int hi, per, ehi, eper, ef, msk;
  int rm[16] = '{4, 12, 5, 6, 7, 14, 14, 15, 1, 2, 3, 10, 11, 4, 4, 4};
  int ra[16] = '{1, 1, 2, 3, 2, 3, 2, 1, 2, 3, 2, 2, 1, 1, 1, 1};
  int rp[16] = '{1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 3, 4, 5};
  int rc[16] = '{5, 0, -1, -1, -1, -1, 0, 16, -1, -1, -1, -1, 32, 1, 1, 1};
  int rt[16] = '{0, 3, 0, 0, 0, 240, 16, 0, 0, 0, 0, 240, 0, 0, 0, 0};

  always #4 pclk = ~pclk;

  timer16_waveform dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe));
  timer16_pin_load load (.wave_out_a(wave_out_a),
    .wave_out_a_oe(wave_out_a_oe), .pin_level(pin_level));

  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_mismatch++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] cw(input int m, a, p, input logic d);
    cw = 32'h0;
    cw[timer16_pkg::CTL_MODE_LSB +: 4] = 4'(m);
    cw[timer16_pkg::CTL_ACTION_LSB +: 2] = 2'(a);
    cw[timer16_pkg::CTL_PRESC_LSB +: 3] = 3'(p);
    cw[timer16_pkg::CTL_DIR_BIT] = d;
  endfunction : cw

  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string s, input logic [11:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rd

  task automatic setup(input int m, a, c, t, p, input logic d);
    wr(timer16_pkg::OFF_CONTROL, 32'h0);
    wr(timer16_pkg::OFF_COMPARE_A, 32'(c));
    wr(timer16_pkg::OFF_CAPTURE_TOP, 32'(t));
    wr(timer16_pkg::OFF_CONTROL, cw(m, a, 0, d));
    wr(timer16_pkg::OFF_COUNTER, 32'h0);
    wr(timer16_pkg::OFF_FLAGS, 32'h7);
    if (p != 0) wr(timer16_pkg::OFF_CONTROL, cw(m, a, p, d));
  endtask : setup

  // Reference waveform: high time, period and flags per mode
  task automatic model(input int m, a, c, t, p);
    int top;
    int dv;
    top = (m == 1 || m == 5) ? 255 : (m == 2 || m == 6) ? 511 :
      (m == 3 || m == 7) ? 1023 : (m == 10 || m == 12 || m == 14) ? t : c;
    dv = (p == 1) ? 1 : (p == 2) ? 8 : (p == 3) ? 64 : (p == 4) ? 256 : 1024;
    if (m == 4 || m == 12 || m == 15) begin
      ehi = top + 1;
      eper = 2 * ehi;
    end else if (a == 1) begin
      ehi = 2 * top;
      eper = 4 * top;
    end else if (m >= 5 && m != 10 && m != 11) begin
      eper = top + 1;
      ehi = (a == 2) ? c + 1 : top - c;
    end else begin
      eper = 2 * top;
      ehi = (a == 2) ? 2 * c : 2 * (top - c);
    end
    ehi *= dv;
    eper *= dv;
    msk = 1 | ((m == 4 || m == 11 || m == 15) ? 2 : 0) |
      ((m == 10 || m == 12 || m == 14) ? 4 : 0);
    ef = (m == 4 || m == 12) ? (msk & 6) : msk;
  endtask : model

  task automatic measure();
    hi = 0;
    do @(posedge pclk); while (pin_level !== 1'b0);
    do @(posedge pclk); while (pin_level !== 1'b1);
    do begin
      @(posedge pclk);
      hi++;
    end while (pin_level === 1'b1);
    per = hi;
    do begin
      @(posedge pclk);
      per++;
    end while (pin_level === 1'b0);
  endtask : measure

  task automatic quiet(input int n);
    int e;
    logic l;
    e = 0;
    l = pin_level;
    repeat (n) begin
      @(posedge pclk);
      if (pin_level !== l) e++;
      l = pin_level;
    end
    chk("pin edges", 32'h0, 32'(e));
  endtask : quiet

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("control", timer16_pkg::OFF_CONTROL, 32'h0);
    rd("flags", timer16_pkg::OFF_FLAGS, 32'h0);
    wr(12'h018, 32'hFFFFFFFF);
    rd("unmapped", 12'h018, 32'h0);
    for (int m = 5; m <= 7; m++) begin
      wr(timer16_pkg::OFF_CONTROL, cw(m, 0, 0, 1'b1));
      wr(timer16_pkg::OFF_COMPARE_A, 32'hFFFF);
      rd("compare", timer16_pkg::OFF_COMPARE_A, (32'h1 << (m + 3)) - 1);
    end
    setup(15, 1, 16, 0, 0, 1'b1);
    wr(timer16_pkg::OFF_COMPARE_A, 32'h30);
    rd("active", timer16_pkg::OFF_ACTIVE_A, 32'h10);
    wr(timer16_pkg::OFF_COUNTER, 32'hF);
    wr(timer16_pkg::OFF_CONTROL, cw(15, 1, 1, 1'b1));
    repeat (20) @(posedge pclk);
    rd("active", timer16_pkg::OFF_ACTIVE_A, 32'h30);
    wr(timer16_pkg::OFF_CONTROL, cw(4, 1, 0, 1'b1));
    wr(timer16_pkg::OFF_COMPARE_A, 32'h22);
    rd("active", timer16_pkg::OFF_ACTIVE_A, 32'h22);
    for (int i = 0; i < 2; i++) begin
      setup(i ? 14 : 12, 0, 0, 16, 0, 1'b1);
      wr(timer16_pkg::OFF_COUNTER, 32'hFFF0);
      wr(timer16_pkg::OFF_CONTROL, cw(i ? 14 : 12, 0, 1, 1'b1));
      rd("flags", timer16_pkg::OFF_FLAGS, 32'h0);
      repeat (40) @(posedge pclk);
      bus(1'b0, timer16_pkg::OFF_FLAGS, 32'h0, q);
      chk("flags", 32'h5, q & 32'h5);
    end
    setup(4, 1, 5, 0, 1, 1'b0);
    quiet(100);
    chk("pin", 32'h0, {31'h0, pin_level});
    setup(4, 0, 5, 0, 1, 1'b1);
    quiet(100);
    setup(5, 2, 255, 0, 1, 1'b1);
    repeat (300) @(posedge pclk);
    quiet(600);
    for (int i = 0; i < 16; i++) begin
      int c;
      c = (rc[i] < 0) ? 1 + int'(rnd() % 200) : rc[i];
      setup(rm[i], ra[i], c, rt[i], rp[i], 1'b1);
      model(rm[i], ra[i], c, rt[i], rp[i]);
      measure();
      chk("high", 32'(ehi), 32'(hi));
      chk("period", 32'(eper), 32'(per));
      bus(1'b0, timer16_pkg::OFF_FLAGS, 32'h0, q);
      chk("flags", 32'(ef), q & 32'(msk));
    end
    complete_run();
  end
endmodule : timer16_waveform_test
